// >>> rtl/pwm_cfg.svh
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
// register byte offsets
`define OFF_CTL_A   8'h00
`define OFF_CTL_B   8'h04
`define OFF_CNT_EN  8'h08
`define OFF_LOAD    8'h0c
`define OFF_WAVE_A  8'h10
`define OFF_WAVE_B  8'h14
`define OFF_PSC     8'h20
`define OFF_PRD     8'h40
`define OFF_CMP     8'h60
`define OFF_STAT    8'h80
// field positions
`define POS_CENTER  0
`define POS_WINDOW  8
`define POS_SHOT    16
`define POS_PAIR    24
`define POS_HI      16
`define POS_DIR     16
`define POS_HALT    17
// codes
`define TYPE_UP     2'h0
`define TYPE_DOWN   2'h1
`define TYPE_UPDOWN 2'h2
`define ACT_NONE    2'h0
`define ACT_LOW     2'h1
`define ACT_HIGH    2'h2
`define ACT_TOGGLE  2'h3
// reset values
`define RST_READY   1'b1
`define RST_OUT     1'b0
`endif

// >>> rtl/pwm_pkg.sv
package pwm_pkg;
  typedef enum logic [2:0] {
    RUN_OFF  = 3'b001,
    RUN_ON   = 3'b010,
    RUN_HALT = 3'b100
  } run_state_t;

  typedef struct packed {
    logic [1:0] zero;
    logic [1:0] prd;
    logic [1:0] cmp_up;
    logic [1:0] cmp_dn;
  } wave_act_t;

  typedef struct packed {
    logic zero;
    logic prd;
    logic cuo;
    logic cue;
    logic cdo;
    logic cde;
  } evt_t;

  typedef struct packed {
    logic [1:0]  ctype;
    logic        shot;
    logic        center;
    logic        win_en;
    logic        win_open;
    logic        run;
    logic [11:0] psc;
    logic [15:0] prd;
    logic [15:0] cmp;
    logic        cmp_wr;
  } cnt_cfg_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        up;
    logic        tick;
    logic [15:0] prd_buf;
    logic [15:0] cmp_buf;
    logic        prd_end;
    run_state_t  st;
  } cnt_view_t;
endpackage : pwm_pkg

// >>> rtl/pwm_counter.sv
`include "pwm_cfg.svh"
module pwm_counter
  import pwm_pkg::*;
(
  input  wire logic     hclk,
  input  wire logic     hresetn,
  input  wire cnt_cfg_t cfg,
  output cnt_view_t     view
);
  typedef struct packed {
    run_state_t  st;
    logic [11:0] psc_cnt;
    logic [11:0] psc_buf;
    logic [15:0] cnt;
    logic [15:0] prd_buf;
    logic [15:0] cmp_buf;
    logic        up;
    logic        again;
  } cstate_t;

  cstate_t s, n;
  logic    tick, prd_end, mid, win_ok, ctr_mode;

  always_comb begin
    n        = s;
    tick     = 1'b0;
    prd_end  = 1'b0;
    mid      = 1'b0;
    win_ok   = !cfg.win_en || cfg.win_open;
    ctr_mode = cfg.center && (cfg.ctype == `TYPE_UPDOWN);
    if (!cfg.run) begin
      n.st      = RUN_OFF;
      n.cnt     = '0;
      n.psc_cnt = '0;
      n.up      = 1'b1;
      n.again   = 1'b0;
      n.psc_buf = cfg.psc;
      n.prd_buf = cfg.prd;
      n.cmp_buf = cfg.cmp;
    end else begin
      unique case (s.st)
        RUN_OFF: n.st = RUN_ON;
        RUN_HALT: begin
          if (cfg.cmp_wr) begin
            n.st      = RUN_ON;
            n.psc_buf = cfg.psc;
            n.prd_buf = cfg.prd;
            n.cmp_buf = cfg.cmp;
          end
        end
        RUN_ON: begin
          if (cfg.cmp_wr && cfg.shot) n.again = 1'b1;
          n.psc_cnt = s.psc_cnt + 12'h001;
          if (s.psc_cnt >= s.psc_buf) begin
            tick      = 1'b1;
            n.psc_cnt = '0;
            if (s.prd_buf == 16'h0000) begin
              n.cnt = '0;
            end else if (cfg.ctype == `TYPE_UPDOWN) begin
              if (s.up && s.cnt >= s.prd_buf) begin
                n.up = 1'b0;
                n.cnt = s.cnt - 16'h0001;
                mid  = 1'b1;
              end else if (s.up) begin
                n.cnt = s.cnt + 16'h0001;
              end else if (s.cnt == 16'h0000) begin
                n.up    = 1'b1;
                n.cnt   = 16'h0001;
                prd_end = 1'b1;
              end else begin
                n.cnt = s.cnt - 16'h0001;
              end
            end else if (cfg.ctype == `TYPE_DOWN) begin
              n.up = 1'b0;
              if (s.cnt == 16'h0000) prd_end = 1'b1;
              else n.cnt = s.cnt - 16'h0001;
            end else begin
              n.up = 1'b1;
              if (s.cnt >= s.prd_buf) begin
                prd_end = 1'b1;
                n.cnt   = '0;
              end else begin
                n.cnt = s.cnt + 16'h0001;
              end
            end
          end
          if (mid && ctr_mode && win_ok) n.cmp_buf = cfg.cmp;
          if (prd_end) begin
            if (win_ok) begin
              n.psc_buf = cfg.psc;
              n.prd_buf = cfg.prd;
              if (!ctr_mode) n.cmp_buf = cfg.cmp;
            end
            if (cfg.ctype == `TYPE_DOWN) n.cnt = n.prd_buf;
            n.again = 1'b0;
            if (cfg.shot && !s.again && !cfg.cmp_wr) begin
              n.st  = RUN_HALT;
              n.cnt = '0;
              n.up  = 1'b1;
            end
          end
        end
        default: n.st = RUN_OFF;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s    <= '0;
      s.st <= RUN_OFF;
      s.up <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign view = '{cnt: s.cnt, up: s.up, tick: tick, prd_buf: s.prd_buf, cmp_buf: s.cmp_buf,
                  prd_end: prd_end, st: s.st};
endmodule : pwm_counter

// >>> rtl/pwm_wave.sv
`include "pwm_cfg.svh"
module pwm_wave
  import pwm_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire cnt_view_t v_e,
  input  wire cnt_view_t v_o,
  input  wire logic [1:0] ty_e,
  input  wire logic [1:0] ty_o,
  input  wire wave_act_t a_e,
  input  wire wave_act_t a_o,
  input  wire logic      comp,
  output logic           out_e,
  output logic           out_o
);
  typedef struct packed {
    logic e;
    logic o;
  } wstate_t;

  wstate_t s, n;
  evt_t    ev_e, ev_o;

  // zero counts as an up point, the turnaround as a down point
  function automatic logic eff_up(cnt_view_t v, logic [1:0] ty);
    if (ty != `TYPE_UPDOWN) return v.up;
    if (v.cnt == 16'h0000) return 1'b1;
    if (v.cnt == v.prd_buf) return 1'b0;
    return v.up;
  endfunction : eff_up

  function automatic evt_t mk(cnt_view_t v, logic [1:0] ty, logic [15:0] cmp_o, logic use_o);
    evt_t e;
    logic u;
    u     = eff_up(v, ty);
    e.zero = v.cnt == 16'h0000;
    e.prd  = v.cnt == v.prd_buf;
    e.cue  = (v.cnt == v.cmp_buf) && u;
    e.cde  = (v.cnt == v.cmp_buf) && !u;
    e.cuo  = use_o && (v.cnt == cmp_o) && u;
    e.cdo  = use_o && (v.cnt == cmp_o) && !u;
    return e;
  endfunction : mk

  function automatic logic [1:0] pick(logic [1:0] ty, logic up, evt_t e,
                                      wave_act_t ae, wave_act_t ao);
    if (ty == `TYPE_UPDOWN && up) begin
      if (e.cuo) return ao.cmp_up;
      if (e.cue) return ae.cmp_up;
      if (e.zero) return ae.zero;
      if (e.cdo) return ao.cmp_dn;
      if (e.cde) return ae.cmp_dn;
    end else if (ty == `TYPE_UPDOWN) begin
      if (e.cdo) return ao.cmp_dn;
      if (e.cde) return ae.cmp_dn;
      if (e.prd) return ae.prd;
      if (e.cuo) return ao.cmp_up;
      if (e.cue) return ae.cmp_up;
    end else if (ty == `TYPE_DOWN) begin
      if (e.zero) return ae.zero;
      if (e.cdo) return ao.cmp_dn;
      if (e.cde) return ae.cmp_dn;
      if (e.prd) return ae.prd;
    end else begin
      if (e.prd) return ae.prd;
      if (e.cuo) return ao.cmp_up;
      if (e.cue) return ae.cmp_up;
      if (e.zero) return ae.zero;
    end
    return `ACT_NONE;
  endfunction : pick

  function automatic logic apply(logic cur, logic [1:0] act);
    unique case (act)
      `ACT_LOW:    return 1'b0;
      `ACT_HIGH:   return 1'b1;
      `ACT_TOGGLE: return ~cur;
      default:     return cur;
    endcase
  endfunction : apply

  always_comb begin
    n    = s;
    ev_e = mk(v_e, ty_e, v_o.cmp_buf, comp);
    ev_o = mk(v_o, ty_o, 16'h0000, 1'b0);
    if (v_e.tick) n.e = apply(s.e, pick(ty_e, eff_up(v_e, ty_e), ev_e, a_e, a_o));
    if (comp) begin
      n.o = ~n.e;
    end else if (v_o.tick) begin
      n.o = apply(s.o, pick(ty_o, eff_up(v_o, ty_o), ev_o, a_o, a_o));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) s <= '{e: `RST_OUT, o: `RST_OUT};
    else s <= n;
  end

  assign out_e = s.e;
  assign out_o = s.o;
endmodule : pwm_wave

// >>> rtl/pwm_top.sv
`include "pwm_cfg.svh"
// How it works
// - center load needs center bit and up-down
// - center load moves compare at period peak
// - prescale and period still load at end
// - center load with window needs open window
// - load bit opens window, period end closes
// - mode bit: one means one-shot, zero auto-reload
// - one-shot holds counter at zero after period
// - compare write restarts stopped one-shot
// - compare write while counting chains next shot
// - repeated writes give one shot, last value
// - auto-reload per load mode; zero period zeroes
// - zero, period, odd/even compare up/down events
// - per event: keep, low, high or toggle
// - up priority: period, odd, even, zero
// - down priority: zero, odd, even, period
// - up-down priorities per counting direction
// - pair mode zero: six independent channels
// - pair mode one: odd output complements even
module pwm_top
  import pwm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [5:0]       pwm_out
);
  typedef struct packed {
    logic                rdy;
    logic                resp;
    logic [31:0]         rdata;
    logic                busy;
    logic                wr;
    logic [7:0]          addr;
    logic [5:0]          center;
    logic [5:0]          win_en;
    logic [5:0]          shot;
    logic [5:0]          run;
    logic [5:0]          win_open;
    logic [5:0]          cmp_wr;
    logic [2:0]          pair;
    logic [5:0][1:0]     ctype;
    wave_act_t [5:0]     wact;
    logic [5:0][11:0]    psc;
    logic [5:0][15:0]    prd;
    logic [5:0][15:0]    cmp;
  } top_t;

  top_t             s, n;
  cnt_view_t [5:0]  view;
  cnt_cfg_t [5:0]   ccfg;
  logic [5:0]       pwm_q;
  logic [2:0]       idx;
  logic             unused_size;

  // per-channel register block lookup
  function automatic logic hit(logic [7:0] a, logic [7:0] base);
    return (a[7:5] == base[7:5]) && (a[4:2] < 3'h6);
  endfunction : hit

  assign idx         = s.addr[4:2];
  assign unused_size = |hsize;

  always_comb begin
    n        = s;
    n.cmp_wr = '0;
    for (int i = 0; i < 6; i++) begin
      if (view[i].prd_end) n.win_open[i] = 1'b0;
    end
    if (s.busy) begin
      n.busy  = 1'b0;
      n.rdy   = 1'b1;
      n.rdata = '0;
      if (s.addr == `OFF_CTL_A) begin
        n.rdata[`POS_CENTER+:6] = s.center;
        n.rdata[`POS_WINDOW+:6] = s.win_en;
      end else if (s.addr == `OFF_CTL_B) begin
        for (int i = 0; i < 6; i++) n.rdata[2*i+:2] = s.ctype[i];
        n.rdata[`POS_SHOT+:6] = s.shot;
        n.rdata[`POS_PAIR+:3] = s.pair;
      end else if (s.addr == `OFF_CNT_EN) begin
        n.rdata[5:0] = s.run;
      end else if (s.addr == `OFF_LOAD) begin
        n.rdata[5:0] = s.win_open;
      end else if (s.addr == `OFF_WAVE_A) begin
        for (int i = 0; i < 6; i++) begin
          n.rdata[2*i+:2]         = s.wact[i].zero;
          n.rdata[`POS_HI+2*i+:2] = s.wact[i].prd;
        end
      end else if (s.addr == `OFF_WAVE_B) begin
        for (int i = 0; i < 6; i++) begin
          n.rdata[2*i+:2]         = s.wact[i].cmp_up;
          n.rdata[`POS_HI+2*i+:2] = s.wact[i].cmp_dn;
        end
      end else if (hit(s.addr, `OFF_PSC)) begin
        n.rdata[11:0] = s.psc[idx];
      end else if (hit(s.addr, `OFF_PRD)) begin
        n.rdata[15:0] = s.prd[idx];
      end else if (hit(s.addr, `OFF_CMP)) begin
        n.rdata[15:0] = s.cmp[idx];
      end else if (hit(s.addr, `OFF_STAT)) begin
        n.rdata[15:0]      = view[idx].cnt;
        n.rdata[`POS_DIR]  = view[idx].up;
        n.rdata[`POS_HALT] = view[idx].st == RUN_HALT;
      end
      if (s.wr) begin
        n.rdata = '0;
        if (s.addr == `OFF_CTL_A) begin
          n.center = hwdata[`POS_CENTER+:6];
          n.win_en = hwdata[`POS_WINDOW+:6];
        end else if (s.addr == `OFF_CTL_B) begin
          for (int i = 0; i < 6; i++) n.ctype[i] = hwdata[2*i+:2];
          n.shot = hwdata[`POS_SHOT+:6];
          n.pair = hwdata[`POS_PAIR+:3];
        end else if (s.addr == `OFF_CNT_EN) begin
          n.run = hwdata[5:0];
        end else if (s.addr == `OFF_LOAD) begin
          n.win_open = n.win_open | hwdata[5:0];
        end else if (s.addr == `OFF_WAVE_A) begin
          for (int i = 0; i < 6; i++) begin
            n.wact[i].zero = hwdata[2*i+:2];
            n.wact[i].prd  = hwdata[`POS_HI+2*i+:2];
          end
        end else if (s.addr == `OFF_WAVE_B) begin
          for (int i = 0; i < 6; i++) begin
            n.wact[i].cmp_up = hwdata[2*i+:2];
            n.wact[i].cmp_dn = hwdata[`POS_HI+2*i+:2];
          end
        end else if (hit(s.addr, `OFF_PSC)) begin
          n.psc[idx] = hwdata[11:0];
        end else if (hit(s.addr, `OFF_PRD)) begin
          n.prd[idx] = hwdata[15:0];
        end else if (hit(s.addr, `OFF_CMP)) begin
          n.cmp[idx]    = hwdata[15:0];
          n.cmp_wr[idx] = 1'b1;
        end
      end
    end else if (hsel && htrans[1] && hready) begin
      n.busy = 1'b1;
      n.rdy  = 1'b0;
      n.wr   = hwrite;
      n.addr = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s     <= '0;
      s.rdy <= `RST_READY;
    end else begin
      s <= n;
    end
  end

  generate
    for (genvar g = 0; g < 6; g++) begin : g_cnt
      assign ccfg[g] = '{ctype: s.ctype[g], shot: s.shot[g], center: s.center[g],
                         win_en: s.win_en[g], win_open: s.win_open[g], run: s.run[g],
                         psc: s.psc[g], prd: s.prd[g], cmp: s.cmp[g], cmp_wr: s.cmp_wr[g]};
      pwm_counter u_cnt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cfg     (ccfg[g]),
        .view    (view[g])
      );
    end
    for (genvar p = 0; p < 3; p++) begin : g_pair
      pwm_wave u_wave (
        .hclk    (hclk),
        .hresetn (hresetn),
        .v_e     (view[2*p]),
        .v_o     (view[2*p+1]),
        .ty_e    (s.ctype[2*p]),
        .ty_o    (s.ctype[2*p+1]),
        .a_e     (s.wact[2*p]),
        .a_o     (s.wact[2*p+1]),
        .comp    (s.pair[p]),
        .out_e   (pwm_q[2*p]),
        .out_o   (pwm_q[2*p+1])
      );
    end
  endgenerate

  assign hreadyout = s.rdy;
  assign hresp     = s.resp;
  assign hrdata    = s.rdata;
  assign pwm_out   = pwm_q;

  a_center_load: assert property (@(posedge hclk) disable iff (!hresetn)
    view[0].tick && view[0].st == RUN_ON && s.ctype[0] == `TYPE_UPDOWN && s.center[0]
    && !s.win_en[0] && view[0].up && view[0].prd_buf != 16'h0000
    && view[0].cnt == view[0].prd_buf |=> view[0].cmp_buf == $past(s.cmp[0]))
    else $error("compare not loaded at period peak");

  a_end_load_only: assert property (@(posedge hclk) disable iff (!hresetn)
    s.run[0] && $past(s.run[0]) && view[0].st == RUN_ON && s.ctype[0] != `TYPE_UPDOWN
    && !s.shot[0] && !view[0].prd_end |=> $stable(view[0].cmp_buf))
    else $error("compare loaded away from period end");

  a_window_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    s.run[4] && $past(s.run[4]) && view[4].st == RUN_ON && !s.shot[4]
    && s.win_en[4] && !s.win_open[4] |=> $stable(view[4].cmp_buf) && $stable(view[4].prd_buf))
    else $error("buffers loaded with window closed");

  a_window_close: assert property (@(posedge hclk) disable iff (!hresetn)
    view[4].prd_end && !s.busy |=> !s.win_open[4])
    else $error("load window still open after period end");

  a_idle_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !s.run[0] |=> view[0].cnt == 16'h0000 && view[0].st == RUN_OFF)
    else $error("counter moves while disabled");

  a_shot_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    view[2].st == RUN_HALT && s.run[2] && !s.cmp_wr[2] |=>
    view[2].st == RUN_HALT && view[2].cnt == 16'h0000)
    else $error("stopped one-shot counter left zero");

  a_shot_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    view[2].st == RUN_HALT && s.run[2] && s.cmp_wr[2] |=>
    view[2].st == RUN_ON && view[2].cmp_buf == $past(s.cmp[2]))
    else $error("compare write did not restart one-shot");

  a_zero_period: assert property (@(posedge hclk) disable iff (!hresetn)
    view[0].tick && view[0].st == RUN_ON && view[0].prd_buf == 16'h0000 && !s.shot[0]
    && s.run[0] |=> view[0].cnt == 16'h0000)
    else $error("counter moved with zero period");

  a_cmp_high: assert property (@(posedge hclk) disable iff (!hresetn)
    view[0].tick && s.ctype[0] == `TYPE_UP && !s.pair[0] && view[0].cnt == view[0].cmp_buf
    && view[0].cnt != view[0].prd_buf && view[0].cnt != 16'h0000
    && s.wact[0].cmp_up == `ACT_HIGH |=> pwm_out[0])
    else $error("compare-up action not applied");

  a_prd_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    view[0].tick && s.ctype[0] == `TYPE_UP && !s.pair[0] && view[0].cnt == view[0].cmp_buf
    && view[0].cnt == view[0].prd_buf && s.wact[0].prd == `ACT_LOW
    && s.wact[0].cmp_up == `ACT_HIGH |=> !pwm_out[0])
    else $error("period event lost to compare");

  a_odd_indep: assert property (@(posedge hclk) disable iff (!hresetn)
    view[1].tick && s.ctype[1] == `TYPE_UP && !s.pair[0] && view[1].cnt == view[1].cmp_buf
    && view[1].cnt != view[1].prd_buf && view[1].cnt != 16'h0000
    && s.wact[1].cmp_up == `ACT_TOGGLE |=> pwm_out[1] != $past(pwm_out[1]))
    else $error("odd channel not running on its own");

  a_pair_comp: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(s.pair[0]) |-> pwm_out[1] == !pwm_out[0])
    else $error("odd output not complement of even");
endmodule : pwm_top

// >>> dv/pwm_switch_model.sv
module pwm_switch_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [5:0]  gate,
  output logic      [15:0] overlap_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] nxt_overlap;
  // counts cycles with both legs of any pair switched on
  always_comb begin
    nxt_overlap = overlap_ff;
    for (int p = 0; p < 3; p++) begin
      if (gate[2*p] && gate[2*p+1]) nxt_overlap = overlap_ff + 16'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) overlap_ff <= 16'h0;
    else overlap_ff <= nxt_overlap;
  end
endmodule : pwm_switch_model

// >>> dv/pwm_pulse_gen_loading_modes_tb.sv
module pwm_pulse_gen_loading_modes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [5:0]  pwm_out;
  logic [15:0] overlap;
  logic [31:0] rd;
  logic [31:0] snap;
  logic [31:0] h;
  logic [31:0] h1;
  int          miscompares;
  int          checked;
  int          plen;
  int          c_ty [9] = '{0, 0, 0, 1, 1, 1, 2, 2, 0};
  int          c_p  [9] = '{0, 6, 6, 6, 6, 6, 6, 6, 6};
  int          c_c  [9] = '{0, 0, 6, 0, 2, 6, 2, 0, 3};
  logic [31:0] c_wa [9] = '{32'h1, 32'h2, 32'h10000, 32'h1, 32'h20000, 32'h10000, 32'h0,
                            32'h2, 32'h3};
  logic [31:0] c_wb [9] = '{32'h2, 32'h1, 32'h2, 32'h20000, 32'h10000, 32'h20000, 32'h10002,
                            32'h1, 32'hc};
  logic [7:0]  rst_a [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h40, 8'h60,
                              8'h80, 8'hfc};

  pwm_top u_pwm_top (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'h2),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .pwm_out   (pwm_out)
  );

  pwm_switch_model u_pwm_switch_model (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .gate       (pwm_out),
    .overlap_ff (overlap)
  );

  always #12.5 hclk = ~hclk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 40);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t: bus wait ran out", $time);
      complete_run;
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask : bus

  // reference waveform: highest event per tick acts, highs counted over 4 periods
  function automatic logic [31:0] model(input int t, input int p, input int c,
                                        input logic [31:0] wa, input logic [31:0] wb);
    int         q[$];
    int         d[$];
    logic [1:0] a;
    logic       o;
    logic [31:0] n;
    if (t == 0) for (int i = 0; i <= p; i++) begin q.push_back(i); d.push_back(1); end
    if (t == 1) for (int i = p; i >= 0; i--) begin q.push_back(i); d.push_back(0); end
    if (t == 2) begin
      for (int i = 0; i < p; i++) begin q.push_back(i); d.push_back(1); end
      for (int i = p; i > 0; i--) begin q.push_back(i); d.push_back(0); end
    end
    o = 1'b0;
    n = 32'h0;
    for (int r = 0; r < 6; r++) begin
      foreach (q[k]) begin
        if (t == 0) a = q[k] == p ? wa[17:16] : q[k] == c ? wb[1:0] : q[k] == 0 ? wa[1:0] : 2'h0;
        else if (t == 1) a = q[k] == 0 ? wa[1:0] : q[k] == c ? wb[17:16] :
                             q[k] == p ? wa[17:16] : 2'h0;
        else if (d[k] == 1) a = q[k] == c ? wb[1:0] : q[k] == 0 ? wa[1:0] : 2'h0;
        else a = q[k] == c ? wb[17:16] : q[k] == p ? wa[17:16] : 2'h0;
        case (a)
          2'h1: o = 1'b0;
          2'h2: o = 1'b1;
          2'h3: o = ~o;
          default: o = o;
        endcase
        if (r >= 2 && o) n = n + 32'h1;
      end
    end
    return n;
  endfunction : model

  task automatic run_case(input int k);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h04, c_ty[k] * 5);
    bus(1'b1, 8'h10, c_wa[k]);
    bus(1'b1, 8'h14, c_wb[k]);
    bus(1'b1, 8'h20, 32'h0);
    bus(1'b1, 8'h40, c_p[k]);
    bus(1'b1, 8'h44, c_p[k]);
    bus(1'b1, 8'h60, c_c[(k + 1) % 9]);
    bus(1'b1, 8'h64, c_c[k]);
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h60, c_c[k]);
    plen = (c_ty[k] == 2) ? 2 * c_p[k] : c_p[k] + 1;
    repeat (3 * plen + 5) @(posedge hclk);
    h = 32'h0;
    h1 = 32'h0;
    repeat (4 * plen) begin
      @(posedge hclk);
      if (pwm_out[0] === 1'b1) h = h + 32'h1;
      if (pwm_out[1] === 1'b1) h1 = h1 + 32'h1;
    end
    chk(h, model(c_ty[k], c_p[k], c_c[k], c_wa[k], c_wb[k]));
    chk(h1, model(c_ty[k], c_p[k], c_c[k], c_wa[k] >> 2, c_wb[k] >> 2));
  endtask : run_case

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    miscompares = 0;
    checked = 0;
    h = $urandom(32'habf1);
    c_p[0] = 4 + $urandom % 8;
    c_c[0] = 1 + $urandom % (c_p[0] - 1);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({26'h0, pwm_out}, 32'h0);
    foreach (rst_a[i]) begin
      bus(1'b0, rst_a[i], 32'h0);
      chk(rd, (rst_a[i] == 8'h80) ? 32'h0001_0000 : 32'h0);
      chk({31'h0, hresp}, 32'h0);
    end
    $display("test reset done");
    bus(1'b1, 8'h00, 32'h1);
    for (int k = 0; k < 9; k++) run_case(k);
    $display("test events done");
    bus(1'b1, 8'h04, 32'h0104_0000);
    repeat (3) @(posedge hclk);
    snap = {16'h0, overlap};
    h = 32'h0;
    repeat (40) begin
      @(posedge hclk);
      if (pwm_out[1] !== ~pwm_out[0]) h = h + 32'h1;
    end
    chk(h, 32'h0);
    chk({16'h0, overlap}, snap);
    $display("test pair done");
    bus(1'b1, 8'h48, 32'd40);
    bus(1'b1, 8'h68, 32'd10);
    bus(1'b1, 8'h28, 32'h0);
    bus(1'b1, 8'h08, 32'h5);
    repeat (60) @(posedge hclk);
    bus(1'b0, 8'h88, 32'h0);
    chk(rd & 32'h2ffff, 32'h20000);
    bus(1'b1, 8'h68, 32'd12);
    repeat (4) @(posedge hclk);
    bus(1'b0, 8'h88, 32'h0);
    chk({31'h0, rd[17]}, 32'h0);
    repeat (10) @(posedge hclk);
    bus(1'b1, 8'h68, 32'd14);
    bus(1'b1, 8'h68, 32'd16);
    repeat (40) @(posedge hclk);
    bus(1'b0, 8'h88, 32'h0);
    chk({31'h0, rd[17]}, 32'h0);
    repeat (40) @(posedge hclk);
    bus(1'b0, 8'h88, 32'h0);
    chk(rd & 32'h2ffff, 32'h20000);
    $display("test one_shot done");
    bus(1'b1, 8'h00, 32'h1000);
    bus(1'b1, 8'h0c, 32'h10);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h10);
    bus(1'b1, 8'h50, 32'd6);
    bus(1'b1, 8'h08, 32'h15);
    repeat (30) @(posedge hclk);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    $display("test window done");
    bus(1'b1, 8'h40, 32'h0);
    repeat (20) @(posedge hclk);
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, 8'h80, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h0);
      repeat (5) @(posedge hclk);
    end
    $display("test zero_period done");
    complete_run;
  end
endmodule : pwm_pulse_gen_loading_modes_tb
